// >>> rtl/jtp_pkg.sv
// shared types, constants and code-group helpers for the jitter test patterns
package jtp_pkg;

  // ==========================================================================
  // pattern selection and byte-wide transmit carrier
  typedef enum logic [2:0]
  {
    PAT_HIGH,
    PAT_LOW,
    PAT_MIXED,
    PAT_LONG,
    PAT_SHORT
  } pattern_t;

  typedef struct packed
  {
    logic [7:0] txd;
    logic       tx_en;
    logic       tx_er;
  } gmii_tx_t;

  // ==========================================================================
  // ten-bit code-groups, bit 9 is the first bit on the line
  localparam logic [9:0] CG_D21_5     = 10'h2AA;
  localparam logic [9:0] CG_K28_5_NEG = 10'h0FA;
  localparam logic [9:0] CG_K28_5_POS = 10'h305;
  localparam logic [9:0] CG_K28_7_NEG = 10'h0F8;
  localparam logic [9:0] CG_K28_7_POS = 10'h307;
  localparam logic       RD_RESET     = 1'b0;   // negative disparity

  // ==========================================================================
  // packet framing counts and fixed octets
  localparam logic [7:0] PRE_BYTE     = 8'h55;
  localparam logic [7:0] SFD_BYTE     = 8'hD5;
  localparam int         PRE_OCTETS   = 8;
  localparam int         SEQ_OCTETS   = 12;
  localparam int         LONG_REPS    = 126;
  localparam int         SHORT_REPS   = 29;
  localparam int         CRC_OCTETS   = 4;
  localparam int         GAP_OCTETS   = 12;
  localparam int         ERR_WIDTH    = 16;

  function automatic logic is_random(input pattern_t p);
    return (p == PAT_LONG) || (p == PAT_SHORT);
  endfunction : is_random

  // encoding picked from the current running disparity
  function automatic logic [9:0] cg_for(input pattern_t p, input logic rd_pos);
    case (p)
      PAT_LOW:   return rd_pos ? CG_K28_7_POS : CG_K28_7_NEG;
      PAT_MIXED: return rd_pos ? CG_K28_5_POS : CG_K28_5_NEG;
      default:   return CG_D21_5;
    endcase
  endfunction : cg_for

  // running disparity after one code-group, sub-block by sub-block
  function automatic logic rd_after(input logic [9:0] cg, input logic rd_in);
    logic [2:0] n6;
    logic [2:0] n4;
    logic       rd;
    n6 = 3'h0;
    n4 = 3'h0;
    rd = rd_in;
    for (int i = 4; i < 10; i++) n6 = n6 + 3'(cg[i]);
    for (int i = 0; i < 4; i++) n4 = n4 + 3'(cg[i]);
    if (n6 > 3'h3) rd = 1'b1;
    else if (n6 < 3'h3) rd = 1'b0;
    else if (cg[9:4] == 6'h07) rd = 1'b1;
    else if (cg[9:4] == 6'h38) rd = 1'b0;
    if (n4 > 3'h2) rd = 1'b1;
    else if (n4 < 3'h2) rd = 1'b0;
    else if (cg[3:0] == 4'h3) rd = 1'b1;
    else if (cg[3:0] == 4'hC) rd = 1'b0;
    return rd;
  endfunction : rd_after

  function automatic logic [7:0] seq_octet(input logic [3:0] idx);
    case (idx)
      4'h0:    return 8'hBE;
      4'h1:    return 8'hD7;
      4'h2:    return 8'h23;
      4'h3:    return 8'h47;
      4'h4:    return 8'h6B;
      4'h5:    return 8'h8F;
      4'h6:    return 8'hB3;
      4'h7:    return 8'h14;
      4'h8:    return 8'h5E;
      4'h9:    return 8'hFB;
      4'hA:    return 8'h35;
      default: return 8'h59;
    endcase
  endfunction : seq_octet

  function automatic logic [7:0] crc_octet(input logic lng,
                                           input logic [1:0] idx);
    case (idx)
      2'h0:    return lng ? 8'h94 : 8'h2F;
      2'h1:    return lng ? 8'hD2 : 8'hE0;
      2'h2:    return lng ? 8'h54 : 8'hAA;
      default: return lng ? 8'hAC : 8'hEF;
    endcase
  endfunction : crc_octet

endpackage : jtp_pkg

// >>> rtl/jtp_rx_checker.sv
// receive-side checker for the repeated code-group patterns
`timescale 1ns/1ns
`default_nettype none

module jtp_rx_checker #(
  parameter int ERR_W = jtp_pkg::ERR_WIDTH
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              check_en,
  input  wire jtp_pkg::pattern_t check_sel,
  input  wire logic [9:0]        rx_cg,
  input  wire logic              rx_cg_valid,
  output var  logic [ERR_W-1:0]  err_count_ff,
  output var  logic              rx_rd_ff
);

  if (ERR_W < 1 || ERR_W > 32)
    $error("jtp_rx_checker: ERR_W out of range");

  logic [9:0] expected;
  logic       mismatch;

  // ==========================================================================
  // expected group from our own copy of the disparity
  assign expected = jtp_pkg::cg_for(check_sel, rx_rd_ff);
  assign mismatch = check_en && rx_cg_valid &&
                    !jtp_pkg::is_random(check_sel) && (rx_cg != expected);

  // disparity follows every valid received group, matching or not, so one bad bit
  // does not leave the checker out of step for the rest of the test
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rx_rd_ff <= jtp_pkg::RD_RESET;
    else if (clk_en && rx_cg_valid)
      rx_rd_ff <= jtp_pkg::rd_after(rx_cg, rx_rd_ff);
  end

  // error count saturates rather than wrapping to zero
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      err_count_ff <= '0;
    else if (clk_en && mismatch && !(&err_count_ff))
      err_count_ff <= err_count_ff + 1'b1;
  end

endmodule : jtp_rx_checker

`default_nettype wire

// >>> rtl/jitter_test_pattern_gen.sv
// transmit jitter test pattern generator with optional receive checker
//
// Behaviour
// - high pattern repeats D21.5 back to back
// - low pattern alternates five ones, five zeros
// - low pattern built from repeated K28.7
// - mixed pattern built from repeated K28.5
// - encoding chosen from current running disparity
// - selected pattern repeats until test ends
// - random packets identical, minimum gap, normally framed
// - random octets presented at byte interface
// - packet starts seven 55 then D5
// - payload repeats fixed twelve-octet sequence
// - long: 126 repetitions then 94 D2 54 AC
// - short: 29 repetitions then 2F E0 AA EF
// - twelve idle octets, enable and error low
// - bit, code-group or frame level allowed
// - receiver may check patterns, report errors
// - checker disparity follows every received group
`timescale 1ns/1ns
`default_nettype none

module jitter_test_pattern_gen #(
  parameter int GAP_LEN = jtp_pkg::GAP_OCTETS,
  parameter int ERR_W   = jtp_pkg::ERR_WIDTH
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              run,
  input  wire jtp_pkg::pattern_t pattern_sel,
  output var  jtp_pkg::gmii_tx_t gmii_tx_ff,
  output var  logic [9:0]        tx_cg_ff,
  output var  logic              tx_cg_valid_ff,
  output var  logic              tx_rd_ff,
  output var  logic              active_ff,
  input  wire logic              check_en,
  input  wire logic [9:0]        rx_cg,
  input  wire logic              rx_cg_valid,
  output var  logic [ERR_W-1:0]  rx_err_count_ff,
  output var  logic              rx_rd_ff
);

  // a gap shorter than the minimum would break the random patterns
  if (GAP_LEN < jtp_pkg::GAP_OCTETS || GAP_LEN > 255)
    $error("jitter_test_pattern_gen: GAP_LEN out of range");

  // ==========================================================================
  // sequencer states
  typedef enum logic [2:0]
  {
    ST_STOP,
    ST_CODE,
    ST_PRE,
    ST_DATA,
    ST_CRC,
    ST_GAP
  } gen_state_t;

  localparam logic [7:0] PRE_LAST   = 8'(jtp_pkg::PRE_OCTETS - 1);
  localparam logic [7:0] SEQ_LAST   = 8'(jtp_pkg::SEQ_OCTETS - 1);
  localparam logic [7:0] CRC_LAST   = 8'(jtp_pkg::CRC_OCTETS - 1);
  localparam logic [7:0] GAP_LAST   = 8'(GAP_LEN - 1);
  localparam logic [6:0] LONG_LAST  = 7'(jtp_pkg::LONG_REPS - 1);
  localparam logic [6:0] SHORT_LAST = 7'(jtp_pkg::SHORT_REPS - 1);

  gen_state_t        state_ff;
  gen_state_t        nxt_state;
  jtp_pkg::pattern_t sel_ff;
  jtp_pkg::pattern_t nxt_sel;
  logic [7:0]        oct_ff;
  logic [6:0]        rep_ff;
  logic [6:0]        rep_last;
  logic [9:0]        cur_cg;

  // repetition count depends on packet length only
  assign rep_last = (sel_ff == jtp_pkg::PAT_LONG) ? LONG_LAST
                                                  : SHORT_LAST;

  // ==========================================================================
  // next state: selection is only taken while stopped or at a code-group or packet boundary
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    case (state_ff)
      ST_STOP, ST_CODE:
      begin
        // every code-group is a boundary, so a new pick lands next group
        nxt_sel = pattern_sel;
        if (!run)
          nxt_state = ST_STOP;
        else if (jtp_pkg::is_random(pattern_sel))
          nxt_state = ST_PRE;
        else
          nxt_state = ST_CODE;
      end
      ST_PRE:
      begin
        if (oct_ff == PRE_LAST)
          nxt_state = ST_DATA;
      end
      ST_DATA:
      begin
        if (oct_ff == SEQ_LAST && rep_ff == rep_last)
          nxt_state = ST_CRC;
      end
      ST_CRC:
      begin
        if (oct_ff == CRC_LAST)
          nxt_state = ST_GAP;
      end
      ST_GAP:
      begin
        // packet boundary: stop, switch pattern or send the next packet
        if (oct_ff == GAP_LAST)
        begin
          nxt_sel = pattern_sel;
          if (!run)
            nxt_state = ST_STOP;
          else if (jtp_pkg::is_random(pattern_sel))
            nxt_state = ST_PRE;
          else
            nxt_state = ST_CODE;
        end
      end
      default:
        nxt_state = ST_STOP;
    endcase
  end

  // state and latched selection
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_STOP;
      sel_ff   <= jtp_pkg::PAT_HIGH;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      sel_ff   <= nxt_sel;
    end
  end

  // ==========================================================================
  // octet counter restarts on each phase, repetition counter per packet
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oct_ff <= 8'h00;
      rep_ff <= 7'h00;
    end
    else if (clk_en)
    begin
      if (nxt_state != state_ff)
        oct_ff <= 8'h00;
      else if (state_ff == ST_DATA && oct_ff == SEQ_LAST)
        oct_ff <= 8'h00;
      else
        oct_ff <= oct_ff + 8'h01;
      if (state_ff != ST_DATA)
        rep_ff <= 7'h00;
      else if (oct_ff == SEQ_LAST)
        rep_ff <= rep_ff + 7'h01;
    end
  end

  // ==========================================================================
  // byte-wide output: octets go ahead of the coding sublayer, which adds
  // its own delimiters and idle sets around them
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      gmii_tx_ff <= '0;
    else if (clk_en)
    begin
      gmii_tx_ff.tx_er <= 1'b0;
      case (state_ff)
        ST_PRE:
        begin
          gmii_tx_ff.tx_en <= 1'b1;
          gmii_tx_ff.txd   <= (oct_ff == PRE_LAST) ? jtp_pkg::SFD_BYTE
                                                   : jtp_pkg::PRE_BYTE;
        end
        ST_DATA:
        begin
          gmii_tx_ff.tx_en <= 1'b1;
          gmii_tx_ff.txd   <= jtp_pkg::seq_octet(oct_ff[3:0]);
        end
        ST_CRC:
        begin
          gmii_tx_ff.tx_en <= 1'b1;
          gmii_tx_ff.txd   <= jtp_pkg::crc_octet(
                                sel_ff == jtp_pkg::PAT_LONG,
                                oct_ff[1:0]);
        end
        default:
        begin
          // gap, stop and code-group modes keep the byte side quiet
          gmii_tx_ff.tx_en <= 1'b0;
          gmii_tx_ff.txd   <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // code-group output for the three repeated patterns; K28.7 sent back to
  // back at negative disparity gives the five-ones, five-zeros stream
  assign cur_cg = jtp_pkg::cg_for(sel_ff, tx_rd_ff);

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_cg_ff       <= jtp_pkg::CG_D21_5;
      tx_cg_valid_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      tx_cg_valid_ff <= (state_ff == ST_CODE);
      if (state_ff == ST_CODE)
        tx_cg_ff <= cur_cg;
    end
  end

  // running disparity advances only with groups actually sent
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      tx_rd_ff <= jtp_pkg::RD_RESET;
    else if (clk_en && state_ff == ST_CODE)
      tx_rd_ff <= jtp_pkg::rd_after(cur_cg, tx_rd_ff);
  end

  // busy flag for the controller
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      active_ff <= 1'b0;
    else if (clk_en)
      active_ff <= (state_ff != ST_STOP);
  end

  // ==========================================================================
  // receive checker, compares against the pattern_sel input rather than the latched selection
  jtp_rx_checker #(
    .ERR_W        (ERR_W)
  ) u_checker (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .check_en     (check_en),
    .check_sel    (pattern_sel),
    .rx_cg        (rx_cg),
    .rx_cg_valid  (rx_cg_valid),
    .err_count_ff (rx_err_count_ff),
    .rx_rd_ff     (rx_rd_ff)
  );

endmodule : jitter_test_pattern_gen

`default_nettype wire

// >>> dv/jtp_gen_checker.sv
// port-level assertions for the jitter test pattern generator
`timescale 1ns/1ns
`default_nettype none

module jtp_gen_checker #(
  parameter int GAP_LEN = 12,
  parameter int ERR_W   = 16
) (
  input wire logic              clock,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  input wire logic              run,
  input wire jtp_pkg::pattern_t pattern_sel,
  input wire jtp_pkg::gmii_tx_t gmii_tx_ff,
  input wire logic [9:0]        tx_cg_ff,
  input wire logic              tx_cg_valid_ff,
  input wire logic              tx_rd_ff,
  input wire logic              active_ff,
  input wire logic              check_en,
  input wire logic [9:0]        rx_cg,
  input wire logic              rx_cg_valid,
  input wire logic [ERR_W-1:0]  rx_err_count_ff,
  input wire logic              rx_rd_ff
);
  // ==========================================================
  // helper state
  logic        rd_ff;    // disparity ahead of the group on show
  logic [10:0] len_ff;   // octets of the packet so far
  logic [7:0]  gap_ff;   // idle octets since the last packet
  logic        seen_ff;  // a packet ended while still active

  // only the K28.5 groups are unbalanced, so only they flip it
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      rd_ff <= 1'b0;
    else if (clk_en && tx_cg_valid_ff && tx_cg_ff inside {10'h0FA, 10'h305})
      rd_ff <= ~rd_ff;

  // packet length and gap counters
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      len_ff <= 11'h000;
    else if (clk_en)
      len_ff <= gmii_tx_ff.tx_en ? len_ff + 11'h001 : 11'h000;

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      gap_ff <= 8'h00;
    else if (clk_en)
      gap_ff <= gmii_tx_ff.tx_en ? 8'h00 : gap_ff + 8'h01;

  // a restart after a stop has no gap to measure
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      seen_ff <= 1'b0;
    else if (!active_ff)
      seen_ff <= 1'b0;
    else if (!gmii_tx_ff.tx_en && len_ff != 11'h000)
      seen_ff <= 1'b1;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_cg_legal:
    assert property (tx_cg_valid_ff |-> tx_cg_ff inside {10'h2AA, 10'h0FA,
      10'h305, 10'h0F8, 10'h307}) else $error("illegal code-group");
  chk_rd_choice:
    assert property (tx_cg_valid_ff && tx_cg_ff != 10'h2AA |->
      tx_cg_ff[9] == rd_ff) else $error("wrong disparity encoding");
  chk_tx_disp:
    assert property (tx_cg_valid_ff |-> tx_rd_ff ==
      (rd_ff ^ (tx_cg_ff inside {10'h0FA, 10'h305})))
      else $error("tx disparity wrong");
  chk_preamble:
    assert property ($rose(gmii_tx_ff.tx_en) |-> (gmii_tx_ff.txd == 8'h55)
      [*7] ##1 gmii_tx_ff.txd == 8'hD5) else $error("bad preamble");
  chk_payload_head:
    assert property (gmii_tx_ff.tx_en && gmii_tx_ff.txd == 8'hD5 |=>
      gmii_tx_ff.txd == 8'hBE) else $error("bad payload start");
  chk_pkt_tail:
    assert property ($fell(gmii_tx_ff.tx_en) |->
      (len_ff == 11'h5F4 && $past(gmii_tx_ff.txd) == 8'hAC) ||
      (len_ff == 11'h168 && $past(gmii_tx_ff.txd) == 8'hEF))
      else $error("bad packet length or tail");
  chk_gap_len:
    assert property ($rose(gmii_tx_ff.tx_en) && seen_ff |->
      gap_ff == 8'(GAP_LEN)) else $error("bad gap length");
  chk_err_low:
    assert property (!gmii_tx_ff.tx_er) else $error("tx_er raised");
  chk_rx_disp:
    assert property (clk_en && rx_cg_valid && rx_cg inside {10'h0FA, 10'h305}
      |=> rx_rd_ff == !$past(rx_cg[9])) else $error("rx disparity stale");
  chk_err_step:
    assert property (clk_en && check_en && rx_cg_valid && rx_cg != 10'h2AA
      && pattern_sel == jtp_pkg::PAT_HIGH && rx_err_count_ff != '1 |=>
      rx_err_count_ff == $past(rx_err_count_ff) + 1'b1)
      else $error("error count missed");

  cov_mixed: cover property (tx_cg_valid_ff && tx_cg_ff == 10'h305);
  cov_gap: cover property ($rose(gmii_tx_ff.tx_en) && seen_ff);
  cov_err: cover property ($changed(rx_err_count_ff));
endmodule : jtp_gen_checker

bind jitter_test_pattern_gen jtp_gen_checker #(
  .GAP_LEN(GAP_LEN),
  .ERR_W  (ERR_W)
) i_jtp_gen_checker (
  .clock           (clock),
  .sys_rst         (sys_rst),
  .clk_en          (clk_en),
  .run             (run),
  .pattern_sel     (pattern_sel),
  .gmii_tx_ff      (gmii_tx_ff),
  .tx_cg_ff        (tx_cg_ff),
  .tx_cg_valid_ff  (tx_cg_valid_ff),
  .tx_rd_ff        (tx_rd_ff),
  .active_ff       (active_ff),
  .check_en        (check_en),
  .rx_cg           (rx_cg),
  .rx_cg_valid     (rx_cg_valid),
  .rx_err_count_ff (rx_err_count_ff),
  .rx_rd_ff        (rx_rd_ff)
);

`default_nettype wire

// >>> dv/jtp_pcs_model.sv
// coding sublayer and serial loopback model for the pattern generator
`timescale 1ns/1ns
`default_nettype none

module jtp_pcs_model (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire jtp_pkg::gmii_tx_t gmii_tx,
  input  wire logic [9:0]        tx_cg,
  input  wire logic              tx_cg_valid,
  input  wire logic              corrupt,
  output var  logic [9:0]        rx_cg,
  output var  logic              rx_cg_valid,
  output var  logic [7:0]        gap_len_ff
);
  logic [7:0] idle_ff;  // gap octets that /T/ /R/ /I1/ /I2/ fill

  // loopback; a released line toggles rather than holding its value
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      rx_cg       <= 10'h000;
      rx_cg_valid <= 1'b0;
    end
    else
    begin
      rx_cg_valid <= tx_cg_valid;
      rx_cg       <= tx_cg_valid ? tx_cg ^ {9'h000, corrupt} : ~rx_cg;
    end

  // the gap must hold /T/ /R/, one /I1/ and four /I2/: twelve octets;
  // its length is kept at each packet start for the bench to compare
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      idle_ff    <= 8'h00;
      gap_len_ff <= 8'h00;
    end
    else
    begin
      idle_ff <= gmii_tx.tx_en ? 8'h00 : idle_ff + 8'h01;
      if (gmii_tx.tx_en && idle_ff != 8'h00)
        gap_len_ff <= idle_ff;
    end
endmodule : jtp_pcs_model

`default_nettype wire

// >>> dv/jitter_test_pattern_gen_tb.sv
// self-checking bench for the jitter test pattern generator
`timescale 1ns/1ns
`default_nettype none

module jitter_test_pattern_gen_tb;
  logic              clock       = 1'b0;
  logic              sys_rst     = 1'b1;
  logic              clk_en      = 1'b1;
  logic              run         = 1'b0;
  logic              check_en    = 1'b0;
  logic              corrupt     = 1'b0;
  jtp_pkg::pattern_t pattern_sel = jtp_pkg::PAT_HIGH;
  jtp_pkg::gmii_tx_t gmii_tx_ff;
  logic [9:0]        tx_cg_ff;
  logic              tx_cg_valid_ff;
  logic              active_ff;
  logic [9:0]        rx_cg;
  logic              rx_cg_valid;
  logic [15:0]       rx_err_count_ff;
  logic [7:0]        gap_len_ff;
  logic              en_q        = 1'b1;
  logic              rand_en     = 1'b0;
  logic [9:0]        got_v;
  logic [9:0]        exp_v;
  logic [9:0]        exp_q[$];
  int                mismatches  = 0;
  int                check_count = 0;
  int                seed        = 32'hDB5D;
  int                n_bad;
  logic [7:0] modified_random_sequence [12] = '{8'hBE, 8'hD7, 8'h23,
    8'h47, 8'h6B, 8'h8F, 8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
  logic [7:0] crc_l [4] = '{8'h94, 8'hD2, 8'h54, 8'hAC};
  logic [7:0] crc_s [4] = '{8'h2F, 8'hE0, 8'hAA, 8'hEF};

  always #20 clock = ~clock;

  jitter_test_pattern_gen i_jitter_test_pattern_gen (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .run(run),
    .pattern_sel(pattern_sel), .gmii_tx_ff(gmii_tx_ff),
    .tx_cg_ff(tx_cg_ff), .tx_cg_valid_ff(tx_cg_valid_ff),
    .tx_rd_ff(), .active_ff(active_ff), .check_en(check_en),
    .rx_cg(rx_cg), .rx_cg_valid(rx_cg_valid),
    .rx_err_count_ff(rx_err_count_ff), .rx_rd_ff());

  jtp_pcs_model i_jtp_pcs_model (
    .clock(clock), .sys_rst(sys_rst), .gmii_tx(gmii_tx_ff),
    .tx_cg(tx_cg_ff), .tx_cg_valid(tx_cg_valid_ff), .corrupt(corrupt),
    .rx_cg(rx_cg), .rx_cg_valid(rx_cg_valid), .gap_len_ff(gap_len_ff));

  task automatic fail(input string m);
    $display("ERROR %0t %s", $time, m);
    mismatches++;
  endtask : fail

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  // a group shown after a frozen edge is the one already compared
  always @(posedge clock)
    en_q <= clk_en;

  // oldest note against each group or octet that shows
  always @(posedge clock)
    if (!sys_rst && en_q && exp_q.size() != 0 &&
        (tx_cg_valid_ff || gmii_tx_ff.tx_en))
    begin
      got_v = tx_cg_valid_ff ? tx_cg_ff : {2'h0, gmii_tx_ff.txd};
      exp_v = exp_q.pop_front();
      check_count++;
      if (got_v !== exp_v) fail("stream mismatch");
    end

  task automatic do_reset();
    sys_rst <= 1'b1;
    run     <= 1'b0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask : do_reset

  task automatic push_pkt(input logic lng);
    repeat (7) exp_q.push_back(10'h055);
    exp_q.push_back(10'h0D5);
    repeat (lng ? 126 : 29)
      foreach (modified_random_sequence[j])
        exp_q.push_back({2'h0, modified_random_sequence[j]});
    for (int k = 0; k < 4; k++)
      exp_q.push_back({2'h0, lng ? crc_l[k] : crc_s[k]});
  endtask : push_pkt

  // start a pattern, drop run after stop_at cycles, wait for the notes
  task automatic go(input jtp_pkg::pattern_t p, input int stop_at);
    int n;
    n = 0;
    pattern_sel <= p;
    run         <= 1'b1;
    while (exp_q.size() != 0 && n < 4000)
    begin
      @(posedge clock);
      n++;
      if (n == stop_at) run <= 1'b0;
      if (rand_en) clk_en <= 1'($random(seed));
    end
    if (n == 4000)
    begin
      fail("stream stalled");
      wrap_up();
    end
    run    <= 1'b0;
    clk_en <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : go

  initial
  begin
    do_reset();
    check_count++;
    if ({gmii_tx_ff, tx_cg_ff, tx_cg_valid_ff, active_ff,
         rx_err_count_ff} !==
        {10'h000, 10'h2AA, 2'h0, 16'h0000}) fail("reset state");
    // code-group patterns from negative disparity; the clock enable
    // drops at random here, and a frozen cycle must not skip or repeat
    for (int i = 0; i < 16; i++) exp_q.push_back(i[0] ? 10'h305 : 10'h0FA);
    rand_en = 1'b1;
    go(jtp_pkg::PAT_MIXED, 0);
    rand_en = 1'b0;
    do_reset();
    repeat (16) exp_q.push_back(10'h0F8);
    go(jtp_pkg::PAT_LOW, 0);
    do_reset();
    repeat (16) exp_q.push_back(10'h2AA);
    go(jtp_pkg::PAT_HIGH, 0);
    do_reset();
    push_pkt(1'b1);
    go(jtp_pkg::PAT_LONG, 0);
    // run drops inside the second packet, which must still finish
    do_reset();
    push_pkt(1'b0);
    push_pkt(1'b0);
    go(jtp_pkg::PAT_SHORT, 400);
    check_count++;
    if (gap_len_ff !== 8'(jtp_pkg::GAP_OCTETS))
      fail("gap length");
    // receive checker counts each damaged group
    do_reset();
    n_bad       = 0;
    check_en    <= 1'b1;
    pattern_sel <= jtp_pkg::PAT_HIGH;
    run         <= 1'b1;
    repeat (4) @(posedge clock);
    repeat (20)
    begin
      corrupt <= 1'($random(seed));
      @(posedge clock);
      n_bad = n_bad + corrupt;
    end
    corrupt <= 1'b0;
    repeat (4) @(posedge clock);
    check_count++;
    if (rx_err_count_ff !== 16'(n_bad)) fail("error count");
    wrap_up();
  end
endmodule : jitter_test_pattern_gen_tb

`default_nettype wire
